// [design/spm_digit_edit.sv]
`timescale 1ns/1ps
module spm_digit_edit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [31:0] load_value,
  input wire logic [3:0] digits,
  input wire logic up,
  input wire logic down,
  input wire logic advance,
  output logic [31:0] value,
  output logic [2:0] pos
);
  wire [31:0] next_value;
  logic [2:0] next_pos;
  logic [3:0] ndig;

  // each digit wraps 0..9 on its own, no carry into neighbours
  for (genvar g = 0; g < 8; g++) begin : gen_digit
    wire [3:0] d = value[4*g +: 4];
    wire here = (pos == 3'(g));
    assign next_value[4*g +: 4] = load ? load_value[4*g +: 4] :
      (here && up) ? ((d >= 4'h9) ? 4'h0 : d + 4'h1) :
      (here && down) ? ((d == 4'h0) ? 4'h9 : d - 4'h1) : d;
  end

  // top digit first, then walk down and wrap
  always_comb begin
    next_pos = pos;
    if (load) begin
      next_pos = 3'(digits - 4'h1);
    end else if (advance) begin
      next_pos = (pos == 3'h0) ? 3'(ndig - 4'h1) : pos - 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= 32'h0000_0000;
      pos <= 3'h0;
      ndig <= 4'h8;
    end else begin
      value <= next_value;
      pos <= next_pos;
      ndig <= load ? digits : ndig;
    end
  end
endmodule

// [design/spm_menu.sv]
`timescale 1ns/1ps
`include "spm_params.svh"
module spm_menu
  import spm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SPM_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire spm_buttons_t buttons,
  input wire logic [19:0] rate_display,
  input wire logic [23:0] rate_scale_factor,
  input wire logic [1:0] rate_timebase,
  input wire logic [2:0] rate_dp,
  output spm_state_t menu_state,
  output logic alarm_one_total_prompt,
  output logic [31:0] edit_value,
  output logic [2:0] edit_digit,
  output logic [2:0] edit_dp,
  output logic [14:0] loop_current_ua
);
  function automatic logic [31:0] spm_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        old[8*i +: 8] = d[8*i +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic [19:0] spm_bcd(input logic [23:0] b);
    logic [19:0] acc;
    acc = 20'h0_0000;
    for (int i = 5; i >= 0; i--) begin
      acc = 20'(acc * 20'h0_000a) + 20'(b[4*i +: 4]);
    end
    return acc;
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  spm_state_t state, next_state;
  spm_buttons_t btn_q, rise;
  spm_ctrl_t ctrl, next_ctrl;
  logic [15:0] acode, next_acode, pcode, next_pcode;
  logic [31:0] sp1, next_sp1, sp2, next_sp2;
  logic [23:0] loop_lo, next_loop_lo, loop_hi, next_loop_hi;
  logic code_for_prog, next_prog, sp_sel, next_sp_sel, hi_sel, next_hi_sel;
  logic [3:0] idle_secs, next_idle;
  logic forced, next_forced, clr_forced, cal_change, primed;
  logic [23:0] scale_q;
  logic [1:0] tb_q;
  logic [2:0] dp_q, next_dp;
  logic ed_load, ed_up, ed_down, ed_adv, sec_tick, press_ev, sp_menu, wr_en, code_ok;
  logic [31:0] ed_value;
  logic [3:0] ed_digits;

  assign rise = buttons & ~btn_q;
  assign press_ev = |rise;
  assign wr_en = awready;
  assign code_ok = edit_value[15:0] == (code_for_prog ? pcode : acode);
  assign sp_menu = !code_for_prog && (state inside {ST_CODE_PROMPT, ST_CODE_EDIT, ST_SP1_PROMPT,
    ST_SP2_PROMPT, ST_SP_EDIT});
  assign cal_change = primed && (rate_scale_factor != scale_q || rate_timebase != tb_q || rate_dp != dp_q);
  assign menu_state = state;
  assign alarm_one_total_prompt = ctrl.alarm_one_total;

  spm_sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(sec_tick)
  );

  spm_digit_edit u_edit (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(ed_load),
    .load_value(ed_value),
    .digits(ed_digits),
    .up(ed_up),
    .down(ed_down),
    .advance(ed_adv),
    .value(edit_value),
    .pos(edit_digit)
  );

  always_comb begin
    next_state = state;
    next_prog = code_for_prog;
    next_sp_sel = sp_sel;
    next_hi_sel = hi_sel;
    next_ctrl = ctrl;
    next_acode = acode;
    next_pcode = pcode;
    next_sp1 = sp1;
    next_sp2 = sp2;
    next_loop_lo = loop_lo;
    next_loop_hi = loop_hi;
    next_idle = idle_secs;
    next_dp = 3'h0;
    clr_forced = 1'b0;
    ed_load = 1'b0;
    ed_value = 32'h0000_0000;
    ed_digits = `SPM_SP_DIGITS;
    ed_up = 1'b0;
    ed_down = 1'b0;
    ed_adv = 1'b0;
    if (state inside {ST_CODE_EDIT, ST_SP_EDIT, ST_LOOP_EDIT}) begin
      ed_up = rise.up;
      ed_down = rise.down;
      ed_adv = rise.select;
    end
    unique case (state)
      ST_DISPLAY: begin
        if (press_ev && buttons.select && buttons.up) begin
          if (ctrl.enable) begin
            next_prog = 1'b0;
            next_state = (acode == `SPM_CODE_RESET) ? ST_SP1_PROMPT : ST_CODE_PROMPT;
          end
        end else if (press_ev && buttons.select && buttons.exit_btn) begin
          next_prog = 1'b1;
          next_state = (pcode == `SPM_CODE_RESET) ? ST_PROG_UPDATE : ST_CODE_PROMPT;
        end
      end
      ST_CODE_PROMPT: begin
        if (rise.select) begin
          ed_load = 1'b1;
          ed_digits = `SPM_CODE_DIGITS;
          next_state = ST_CODE_EDIT;
        end else if (rise.exit_btn) begin
          next_state = ST_DISPLAY;
        end
      end
      ST_CODE_EDIT: begin
        if (rise.exit_btn) begin
          next_state = !code_ok ? ST_DISPLAY : (code_for_prog ? ST_PROG_UPDATE : ST_SP1_PROMPT);
        end
      end
      ST_SP1_PROMPT, ST_SP2_PROMPT: begin
        if (rise.up || rise.down) begin
          next_state = (state == ST_SP1_PROMPT) ? ST_SP2_PROMPT : ST_SP1_PROMPT;
        end else if (rise.select) begin
          ed_load = 1'b1;
          next_sp_sel = (state == ST_SP2_PROMPT);
          ed_value = (state == ST_SP2_PROMPT) ? sp2 : sp1;
          next_state = ST_SP_EDIT;
        end else if (rise.exit_btn) begin
          next_state = ST_DISPLAY;
        end
      end
      ST_SP_EDIT: begin
        if (rise.exit_btn) begin
          next_sp1 = sp_sel ? sp1 : edit_value;
          next_sp2 = sp_sel ? edit_value : sp2;
          next_state = sp_sel ? ST_SP2_PROMPT : ST_SP1_PROMPT;
        end
      end
      ST_PROG_UPDATE, ST_PROG_LOOP: begin
        if (rise.up || rise.down) begin
          next_state = (state == ST_PROG_UPDATE) ? ST_PROG_LOOP : ST_PROG_UPDATE;
        end else if (rise.select && state == ST_PROG_LOOP) begin
          next_state = ST_LOOP_LO;
        end else if (rise.exit_btn) begin
          next_state = ST_DISPLAY;
        end
      end
      ST_LOOP_LO, ST_LOOP_HI: begin
        if (rise.up || rise.down) begin
          next_state = (state == ST_LOOP_LO) ? ST_LOOP_HI : ST_LOOP_LO;
        end else if (rise.select) begin
          ed_load = 1'b1;
          ed_digits = `SPM_LOOP_DIGITS;
          next_hi_sel = (state == ST_LOOP_HI);
          ed_value = {8'h00, (state == ST_LOOP_HI) ? loop_hi : loop_lo};
          next_dp = rate_dp;
          next_state = ST_LOOP_EDIT;
        end else if (rise.exit_btn) begin
          next_state = ST_PROG_LOOP;
        end
      end
      ST_LOOP_EDIT: begin
        next_dp = rate_dp;
        if (rise.exit_btn) begin
          next_loop_lo = hi_sel ? loop_lo : edit_value[23:0];
          next_loop_hi = hi_sel ? edit_value[23:0] : loop_hi;
          clr_forced = 1'b1;
          next_dp = 3'h0;
          next_state = hi_sel ? ST_LOOP_HI : ST_LOOP_LO;
        end
      end
      default: next_state = ST_DISPLAY;
    endcase
    // idle timer, restarted by any press
    if (!sp_menu || press_ev) begin
      next_idle = 4'h0;
    end else if (sec_tick) begin
      next_idle = idle_secs + 4'h1;
      if (idle_secs == `SPM_IDLE_TIMEOUT_S - 4'h1) begin
        next_state = ST_DISPLAY;
      end
    end
    if (wr_en) begin
      unique case (awaddr)
        `SPM_ADDR_CTRL: next_ctrl = wstrb[0] ? spm_ctrl_t'(wdata[1:0]) : ctrl;
        `SPM_ADDR_ACODE: next_acode = 16'(spm_merge({16'h0000, acode}, wdata, wstrb));
        `SPM_ADDR_PCODE: next_pcode = 16'(spm_merge({16'h0000, pcode}, wdata, wstrb));
        `SPM_ADDR_SP1: next_sp1 = spm_merge(sp1, wdata, wstrb);
        `SPM_ADDR_SP2: next_sp2 = spm_merge(sp2, wdata, wstrb);
        `SPM_ADDR_LOOP_LO: begin
          next_loop_lo = 24'(spm_merge({8'h00, loop_lo}, wdata, wstrb));
          clr_forced = 1'b1;
        end
        `SPM_ADDR_LOOP_HI: begin
          next_loop_hi = 24'(spm_merge({8'h00, loop_hi}, wdata, wstrb));
          clr_forced = 1'b1;
        end
        default: next_ctrl = ctrl;
      endcase
    end
    // calibration change wins over a clear
    next_forced = cal_change ? 1'b1 : (clr_forced ? 1'b0 : forced);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_DISPLAY;
      btn_q <= 4'h0;
      code_for_prog <= 1'b0;
      sp_sel <= 1'b0;
      hi_sel <= 1'b0;
      ctrl <= `SPM_CTRL_RESET;
      acode <= `SPM_CODE_RESET;
      pcode <= `SPM_CODE_RESET;
      sp1 <= `SPM_SP_RESET;
      sp2 <= `SPM_SP_RESET;
      loop_lo <= `SPM_LOOP_RESET;
      loop_hi <= `SPM_LOOP_RESET;
      idle_secs <= 4'h0;
      forced <= 1'b1;
      primed <= 1'b0;
      scale_q <= 24'h00_0000;
      tb_q <= 2'h0;
      dp_q <= 3'h0;
      edit_dp <= 3'h0;
    end else begin
      state <= next_state;
      btn_q <= buttons;
      code_for_prog <= next_prog;
      sp_sel <= next_sp_sel;
      hi_sel <= next_hi_sel;
      ctrl <= next_ctrl;
      acode <= next_acode;
      pcode <= next_pcode;
      sp1 <= next_sp1;
      sp2 <= next_sp2;
      loop_lo <= next_loop_lo;
      loop_hi <= next_loop_hi;
      idle_secs <= next_idle;
      forced <= next_forced;
      primed <= 1'b1;
      scale_q <= rate_scale_factor;
      tb_q <= rate_timebase;
      dp_q <= rate_dp;
      edit_dp <= next_dp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop current: serial restoring divide, one step per cycle
  logic [20:0] rem, next_rem, trial;
  logic [39:0] numq, next_numq, quo;
  logic [19:0] den, next_den, lo_bin, hi_bin, diff;
  logic [5:0] div_cnt, next_cnt;
  logic neg, next_neg, ge;
  logic [14:0] next_loop;

  always_comb begin
    lo_bin = spm_bcd(loop_lo);
    hi_bin = spm_bcd(loop_hi);
    diff = (rate_display >= lo_bin) ? rate_display - lo_bin : lo_bin - rate_display;
    trial = {rem[19:0], numq[39]};
    ge = trial >= {1'b0, den};
    quo = {numq[38:0], ge};
    next_rem = rem;
    next_numq = numq;
    next_den = den;
    next_neg = neg;
    next_loop = loop_current_ua;
    next_cnt = div_cnt - 6'h01;
    if (div_cnt == 6'h00) begin
      next_den = (hi_bin >= lo_bin) ? hi_bin - lo_bin : lo_bin - hi_bin;
      next_neg = (rate_display < lo_bin) ^ (hi_bin < lo_bin);
      next_numq = 40'(diff) * 40'(`SPM_SPAN_UA);
      next_rem = 21'h00_0000;
      next_cnt = `SPM_DIV_STEPS;
    end else begin
      next_rem = ge ? trial - {1'b0, den} : trial;
      next_numq = quo;
      if (div_cnt == 6'h01) begin
        if (den == 20'h0_0000) begin
          next_loop = `SPM_LOOP_FLOOR_UA;
        end else if (neg) begin
          next_loop = (quo > 40'(`SPM_LOOP_ZERO_UA - `SPM_LOOP_FLOOR_UA)) ? `SPM_LOOP_FLOOR_UA :
            `SPM_LOOP_ZERO_UA - quo[14:0];
        end else begin
          next_loop = (quo > 40'(`SPM_LOOP_CEIL_UA - `SPM_LOOP_ZERO_UA)) ? `SPM_LOOP_CEIL_UA :
            `SPM_LOOP_ZERO_UA + quo[14:0];
        end
      end
    end
    if (forced) begin
      next_loop = `SPM_LOOP_FLOOR_UA;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem <= 21'h00_0000;
      numq <= 40'h00_0000_0000;
      den <= 20'h0_0000;
      neg <= 1'b0;
      div_cnt <= 6'h00;
      loop_current_ua <= `SPM_LOOP_FLOOR_UA;
    end else begin
      rem <= next_rem;
      numq <= next_numq;
      den <= next_den;
      neg <= next_neg;
      div_cnt <= next_cnt;
      loop_current_ua <= next_loop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aw and w are taken together, so either arrival order just waits
  logic next_awready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_comb begin
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    if (awready) begin
      next_bvalid = 1'b1;
      next_bresp = (awaddr <= `SPM_ADDR_STATUS && awaddr[1:0] == 2'h0) ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
    end
    next_arready = arvalid && !arready && !rvalid;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arready) begin
      next_rvalid = 1'b1;
      next_rresp = `SPM_RESP_OKAY;
      unique case (araddr)
        `SPM_ADDR_CTRL: next_rdata = {30'h0000_0000, ctrl};
        `SPM_ADDR_ACODE: next_rdata = {16'h0000, acode};
        `SPM_ADDR_PCODE: next_rdata = {16'h0000, pcode};
        `SPM_ADDR_SP1: next_rdata = sp1;
        `SPM_ADDR_SP2: next_rdata = sp2;
        `SPM_ADDR_LOOP_LO: next_rdata = {8'h00, loop_lo};
        `SPM_ADDR_LOOP_HI: next_rdata = {8'h00, loop_hi};
        `SPM_ADDR_STATUS: next_rdata = {loop_current_ua, forced, 5'h00, state};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `SPM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SPM_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SPM_RESP_OKAY;
    end else begin
      awready <= next_awready;
      wready <= next_awready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_combo;
    state == ST_DISPLAY && press_ev && buttons.select && buttons.up;
  endsequence
  sequence s_good_code_exit;
    state == ST_CODE_EDIT && rise.exit_btn && !code_for_prog && code_ok;
  endsequence

  chk_combo_open: assert property (s_combo and ctrl.enable && acode == 16'h0000 |=> state == ST_SP1_PROMPT)
    else $error("combo without code did not open alarm one prompt");
  chk_code_first: assert property (s_combo and ctrl.enable && acode != 16'h0000 |=> state == ST_CODE_PROMPT)
    else $error("combo with code did not show code prompt");
  chk_combo_disabled: assert property (s_combo and !ctrl.enable |=> state == ST_DISPLAY)
    else $error("disabled menu opened");
  chk_code_accept: assert property (s_good_code_exit |=> state == ST_SP1_PROMPT)
    else $error("correct code did not reach alarm one prompt");
  chk_bad_code: assert property (state == ST_CODE_EDIT && rise.exit_btn && !code_ok |=> state == ST_DISPLAY)
    else $error("wrong code did not return to display");
  chk_idle_return: assert property (sp_menu && sec_tick && !press_ev && idle_secs == 4'h9 |=> state == ST_DISPLAY)
    else $error("idle timeout did not return to display");
  chk_idle_restart: assert property (sp_menu && press_ev |=> idle_secs == 4'h0)
    else $error("press did not restart idle timer");
  chk_sp_toggle: assert property (state == ST_SP1_PROMPT && rise.up |=> state == ST_SP2_PROMPT)
    else $error("up did not toggle setpoint prompt");
  chk_sp_back: assert property (state == ST_SP_EDIT && rise.exit_btn |=> state inside {ST_SP1_PROMPT, ST_SP2_PROMPT})
    else $error("exit from setpoint edit missed prompt");
  chk_prog_entry: assert property (state == ST_DISPLAY && press_ev && buttons.select && buttons.exit_btn
    && !buttons.up && pcode == 16'h0000 |=> state == ST_PROG_UPDATE)
    else $error("programme mode did not open on update item");
  chk_forced_floor: assert property (forced |=> loop_current_ua == 15'h0dac)
    else $error("forced loop current not at floor");
  chk_cal_forces: assert property (cal_change |=> forced ##1 loop_current_ua == 15'h0dac)
    else $error("calibration change did not force floor");
  chk_loop_range: assert property (loop_current_ua >= 15'h0dac && loop_current_ua <= 15'h55f0)
    else $error("loop current out of linear range");
  chk_hi_exit: assert property (state == ST_LOOP_EDIT && rise.exit_btn && hi_sel |=> state == ST_LOOP_HI
    ##0 !forced || $past(cal_change))
    else $error("high end edit exit misrouted");
  chk_loop_dp: assert property (state == ST_LOOP_EDIT && !rise.exit_btn |=> edit_dp == $past(rate_dp))
    else $error("loop edit point not fixed at rate point");
endmodule

// [design/spm_params.svh]
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH
// Function
// - in display mode, select pressed together with up opens the setpoint menu if that menu is enabled.
// - an access code of all zeros means no code, so the menu opens straight away.
// - without a code the menu opens on the alarm one prompt, rate or total variant per alarm one type.
// - with a code the code prompt comes first; select starts digit entry, up/down change, select advances.
// - exit after a correct code shows the alarm one setpoint prompt.
// - a wrong code or ten seconds without a press returns to display mode.
// - in the setpoint menu up or down toggles between the alarm one and alarm two prompts.
// - select on a prompt reveals the setpoint for digit editing with up, down and select.
// - exit after editing returns to that prompt, and a further exit returns to display mode.
// - with the menu disabled the select and up combination does nothing.
// - programme mode opens on the update interval item without a code, otherwise asks for the code.
// - the loop output low and high ends each map to any chosen rate value, linear between.
// - loop calibration shows the low prompt; select reveals the value, top digit first, rate point fixed.
// - exit returns to the low prompt, up/down selects the high prompt, three exits reach display mode.
// - the output may rise or fall with rate and stays linear from 3.5 to 22 mA.
// - a change of rate scale, timebase or rate point forces 3.5 mA until recalibrated.

`define SPM_ADDR_CTRL 8'h00
`define SPM_ADDR_ACODE 8'h04
`define SPM_ADDR_PCODE 8'h08
`define SPM_ADDR_SP1 8'h0c
`define SPM_ADDR_SP2 8'h10
`define SPM_ADDR_LOOP_LO 8'h14
`define SPM_ADDR_LOOP_HI 8'h18
`define SPM_ADDR_STATUS 8'h1c
`define SPM_RESP_OKAY 2'h0
`define SPM_RESP_SLVERR 2'h2

`define SPM_CTRL_RESET 2'h0
`define SPM_CODE_RESET 16'h0000
`define SPM_SP_RESET 32'h0000_0000
`define SPM_LOOP_RESET 24'h00_0000

`define SPM_CODE_DIGITS 4'h4
`define SPM_SP_DIGITS 4'h8
`define SPM_LOOP_DIGITS 4'h6

`define SPM_CLK_PERIOD_NS 32'h0000_0032
`define SPM_SECOND_NS 32'h3b9a_ca00
`define SPM_TICK_CYCLES (`SPM_SECOND_NS / `SPM_CLK_PERIOD_NS)
`define SPM_IDLE_TIMEOUT_S 4'ha

`define SPM_LOOP_FLOOR_UA 15'h0dac
`define SPM_LOOP_ZERO_UA 15'h0fa0
`define SPM_LOOP_CEIL_UA 15'h55f0
`define SPM_SPAN_UA 15'h3e80
`define SPM_DIV_STEPS 6'h28
`endif

// [design/spm_pkg.sv]
package spm_pkg;
  typedef enum logic [10:0] {
    ST_DISPLAY = 11'h001,
    ST_CODE_PROMPT = 11'h002,
    ST_CODE_EDIT = 11'h004,
    ST_SP1_PROMPT = 11'h008,
    ST_SP2_PROMPT = 11'h010,
    ST_SP_EDIT = 11'h020,
    ST_PROG_UPDATE = 11'h040,
    ST_PROG_LOOP = 11'h080,
    ST_LOOP_LO = 11'h100,
    ST_LOOP_HI = 11'h200,
    ST_LOOP_EDIT = 11'h400
  } spm_state_t;

  typedef struct packed {
    logic select;
    logic up;
    logic down;
    logic exit_btn;
  } spm_buttons_t;

  typedef struct packed {
    logic enable;
    logic alarm_one_total;
  } spm_ctrl_t;
endpackage

// [design/spm_sec_tick.sv]
`timescale 1ns/1ps
module spm_sec_tick #(
  parameter int unsigned CYCLES = 20000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [24:0] count;
  logic [24:0] next_count;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_count = count + 25'h000_0001;
    if (count >= 25'(CYCLES - 1)) begin
      next_count = 25'h000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 25'h000_0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// [test/spm_operator.sv]
`timescale 1ns/1ps
module spm_operator
  import spm_pkg::*;
(
  input wire logic aclk,
  output spm_buttons_t buttons
);
  initial buttons = '0;
  // released buttons read low, so each press shows a fresh rise
  task automatic press(input logic [3:0] code);
    @(posedge aclk);
    buttons <= code;
    repeat (2) @(posedge aclk);
    buttons <= '0;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import spm_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, alarm_one_total_prompt;
  logic [31:0] wdata = 0, rdata, rd, edit_value;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, br, rate_timebase = 0;
  logic [19:0] rate_display = 0;
  logic [23:0] rate_scale_factor = 0;
  logic [2:0] rate_dp = 0, edit_digit, edit_dp;
  logic [14:0] loop_current_ua;
  spm_state_t menu_state;
  spm_buttons_t buttons;
  int mismatches = 0, checked = 0, cycles = 0;
  localparam logic [3:0] SEL = 4'h8, UP = 4'h4, EXT = 4'h1;
  always #25 aclk = ~aclk;
  spm_menu #(.TICK_CYCLES(20)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .buttons, .rate_display, .rate_scale_factor, .rate_timebase, .rate_dp, .menu_state,
    .alarm_one_total_prompt, .edit_value, .edit_digit, .edit_dp, .loop_current_ua);
  spm_operator op (.aclk, .buttons);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    // one edge apart, so a back-to-back call never re-drives bready in the same step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    br = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata;
    rready <= 1'h0;
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ceiling well above the roughly 1000 cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check("loop floor", loop_current_ua, 15'h0dac);
    op.press(SEL | UP);
    check("disabled", menu_state, ST_DISPLAY);
    axw(8'h00, 32'h0000_0003);
    op.press(SEL | UP);
    check("enter", menu_state, ST_SP1_PROMPT);
    check("total", alarm_one_total_prompt, 1'h1);
    op.press(UP);
    check("toggle", menu_state, ST_SP2_PROMPT);
    op.press(SEL);
    check("top digit", edit_digit, 3'h7);
    op.press(UP);
    op.press(SEL);
    check("next digit", edit_digit, 3'h6);
    op.press(EXT);
    check("prompt", menu_state, ST_SP2_PROMPT);
    op.press(EXT);
    check("display", menu_state, ST_DISPLAY);
    axr(8'h10);
    check("sp2", rd, 32'h1000_0000);
    $display("setpoint test done");
    op.press(SEL | UP);
    repeat (150) @(posedge aclk);
    op.press(UP);
    repeat (150) @(posedge aclk);
    check("idle restart", menu_state, ST_SP2_PROMPT);
    repeat (100) @(posedge aclk);
    check("idle exit", menu_state, ST_DISPLAY);
    $display("idle test done");
    axw(8'h04, 32'h0000_0001);
    op.press(SEL | UP);
    check("code prompt", menu_state, ST_CODE_PROMPT);
    op.press(SEL);
    op.press(EXT);
    check("wrong code", menu_state, ST_DISPLAY);
    op.press(SEL | UP);
    repeat (4) op.press(SEL);
    op.press(UP);
    check("code", edit_value[15:0], 16'h0001);
    op.press(EXT);
    check("code ok", menu_state, ST_SP1_PROMPT);
    op.press(EXT);
    $display("code test done");
    axw(8'h18, 32'h0000_0100);
    rate_display <= 20'h0_0019;
    repeat (100) @(posedge aclk);
    check("rising", loop_current_ua, 15'h1f40);
    axw(8'h14, 32'h0000_0100);
    axw(8'h18, 32'h0000_0000);
    repeat (100) @(posedge aclk);
    check("falling", loop_current_ua, 15'h3e80);
    rate_scale_factor <= 24'h00_0001;
    repeat (100) @(posedge aclk);
    check("recal", loop_current_ua, 15'h0dac);
    // point change forces again; the high end is then edited from the panel
    rate_dp <= 3'h2;
    op.press(SEL | EXT);
    check("prog entry", menu_state, ST_PROG_UPDATE);
    op.press(UP);
    op.press(SEL);
    check("low prompt", menu_state, ST_LOOP_LO);
    op.press(UP);
    op.press(SEL);
    check("loop digit", edit_digit, 3'h5);
    check("loop point", edit_dp, 3'h2);
    op.press(UP);
    op.press(EXT);
    check("high prompt", menu_state, ST_LOOP_HI);
    repeat (100) @(posedge aclk);
    check("recalibrated", loop_current_ua, 15'h0f94);
    repeat (2) op.press(EXT);
    check("three exits", menu_state, ST_DISPLAY);
    axr(8'h20);
    check("unmapped", rresp, 2'h2);
    axw(8'h20, 32'h0000_0000);
    check("bad write", br, 2'h2);
    $display("loop test done");
    give_verdict();
  end
endmodule
